// file: verilog/falsr_top.v
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "falsr_defs.vh"

module falsr_top #(
  parameter MS_CYCLES = `FALSR_MS_NS / `FALSR_CLK_NS,
  parameter PRE_W     = 18
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // State requests from the bus master
  input  wire        state_req_valid,
  input  wire [3:0]  state_req,
  // Conditions from the fieldbus core
  input  wire        sm_cfg_bad,
  input  wire        inputs_valid,
  input  wire        outputs_valid,
  input  wire        cold_start_req,
  input  wire        freerun_no_3buf,
  input  wire        dc_sync_cfg_bad,
  input  wire        dc_latch_cfg_bad,
  input  wire        dc_sync_timeout,
  input  wire        dc_cycle_bad,
  input  wire        dev_id_update,
  input  wire [15:0] master_alias,
  // Process data from master and drive application
  input  wire        pd_valid,
  input  wire [15:0] pd_ctrl_word,
  input  wire [15:0] drv_status_word,
  // Outputs to drive application and master
  output reg  [15:0] drv_ctrl_word,
  output reg  [15:0] pd_status_word,
  output reg  [3:0]  al_state,
  output reg         al_error_flag,
  output reg  [15:0] app_layer_error_code,
  output reg  [1:0]  operate_mode,
  output reg  [15:0] sync_manager_watchdog_time,
  output reg  [15:0] station_alias_used
);

  localparam [31:0]      PRE_CNT  = MS_CYCLES - 1;
  localparam [PRE_W-1:0] PRE_LAST = PRE_CNT[PRE_W-1:0];

  // Byte-lane merge for register writes
  function [31:0] falsr_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer i;
    begin
      falsr_merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i])
          falsr_merge[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
  endfunction

  // Standard profile control word to drive-native control word
  function [15:0] falsr_ctrl_to_drive;
    input [15:0] cw;
    begin
      falsr_ctrl_to_drive        = 16'h0000;
      falsr_ctrl_to_drive[0]     = cw[0] & cw[1] & cw[2] & cw[3];
      falsr_ctrl_to_drive[2]     = cw[7];
    end
  endfunction

  // Drive-native status word to standard profile status word
  function [15:0] falsr_stat_to_profile;
    input [15:0] sw;
    begin
      falsr_stat_to_profile      = 16'h0000;
      falsr_stat_to_profile[0]   = sw[0];
      falsr_stat_to_profile[1]   = sw[0];
      falsr_stat_to_profile[2]   = sw[1];
      falsr_stat_to_profile[3]   = sw[3];
      falsr_stat_to_profile[4]   = sw[0];
      falsr_stat_to_profile[5]   = 1'b1;
      falsr_stat_to_profile[7]   = sw[2];
      falsr_stat_to_profile[9]   = 1'b1;
    end
  endfunction

  // Register file and state
  reg  [1:0]       mode_reg;
  reg  [15:0]      wdtime_reg;
  reg  [15:0]      aliaspar_reg;
  reg  [15:0]      alias_boot_reg;
  reg              alias_caught_reg;
  reg  [3:0]       state_reg;
  reg  [3:0]       state_next;
  reg              err_reg;
  reg              err_next;
  reg  [15:0]      code_reg;
  reg  [15:0]      code_next;
  reg  [PRE_W-1:0] pre_reg;
  reg  [15:0]      ms_reg;
  reg  [15:0]      pd_ctrl_reg;
  // Bus handshake state
  reg              aw_full_reg;
  reg              w_full_reg;
  reg  [7:0]       awaddr_reg;
  reg  [31:0]      wdata_reg;
  reg  [3:0]       wstrb_reg;
  // Decode intermediates
  reg              ev_hit;
  reg  [15:0]      ev_code;
  reg  [3:0]       ev_state;
  reg              rq_err;
  reg  [15:0]      rq_code;
  reg  [31:0]      rd_val;
  reg              rd_ok;

  wire aw_take   = s_axi_awvalid & s_axi_awready;
  wire w_take    = s_axi_wvalid & s_axi_wready;
  wire wr_do     = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  wire b_done    = s_axi_bvalid & s_axi_bready;
  wire ar_take   = s_axi_arvalid & s_axi_arready;
  wire r_done    = s_axi_rvalid & s_axi_rready;
  wire aw_full_n = b_done ? 1'b0 : (aw_take ? 1'b1 : aw_full_reg);
  wire w_full_n  = b_done ? 1'b0 : (w_take ? 1'b1 : w_full_reg);
  wire rvalid_n  = ar_take ? 1'b1 : (r_done ? 1'b0 : s_axi_rvalid);
  wire st_init   = (state_reg == `FALSR_ST_INIT);
  wire st_pre    = (state_reg == `FALSR_ST_PREOP);
  wire st_safe   = (state_reg == `FALSR_ST_SAFEOP);
  wire st_op     = (state_reg == `FALSR_ST_OP);
  wire wd_expire = st_op & (wdtime_reg != 16'h0000) &
                   (ms_reg >= wdtime_reg);
  wire [15:0] alias_now = (aliaspar_reg != 16'h0000) ? aliaspar_reg :
                          alias_boot_reg;
  // Merged write words, cut to each register's width at the write
  wire [31:0] mode_wr  = falsr_merge({30'h0, mode_reg}, wdata_reg,
                                     wstrb_reg);
  wire [31:0] wdt_wr   = falsr_merge({16'h0, wdtime_reg}, wdata_reg,
                                     wstrb_reg);
  wire [31:0] alias_wr = falsr_merge({16'h0, aliaspar_reg}, wdata_reg,
                                     wstrb_reg);

  // Running events, evaluated without a request
  always @* begin
    ev_hit   = 1'b0;
    ev_code  = `FALSR_EC_NONE;
    ev_state = state_reg;
    if (cold_start_req) begin
      ev_hit   = 1'b1;
      ev_code  = `FALSR_EC_COLDSTART;
      ev_state = st_op ? `FALSR_ST_SAFEOP : state_reg;
    end else if (st_op & ~inputs_valid & ~outputs_valid) begin
      ev_hit   = 1'b1;
      ev_code  = `FALSR_EC_NOIO;
      ev_state = `FALSR_ST_SAFEOP;
    end else if ((st_op | st_safe) & ~inputs_valid) begin
      ev_hit   = 1'b1;
      ev_code  = `FALSR_EC_NOINPUTS;
      ev_state = `FALSR_ST_SAFEOP;
    end else if (st_op & dc_sync_cfg_bad) begin
      ev_hit   = 1'b1;
      ev_code  = `FALSR_EC_DCSYNCCFG;
      ev_state = `FALSR_ST_SAFEOP;
    end else if (st_op & dc_latch_cfg_bad) begin
      ev_hit   = 1'b1;
      ev_code  = `FALSR_EC_DCLATCHCFG;
      ev_state = `FALSR_ST_SAFEOP;
    end else if (st_op & dc_sync_timeout) begin
      ev_hit   = 1'b1;
      ev_code  = `FALSR_EC_DCTIMEOUT;
      ev_state = `FALSR_ST_SAFEOP;
    end else if (wd_expire) begin
      ev_hit   = 1'b1;
      ev_code  = `FALSR_EC_SMWDOG;
      ev_state = `FALSR_ST_SAFEOP;
    end else if (st_pre & dev_id_update) begin
      ev_hit   = 1'b1;
      ev_code  = `FALSR_EC_IDUPDATE;
      ev_state = `FALSR_ST_PREOP;
    end
    // A standing condition already reported does not block requests
    if (err_reg & (code_reg == ev_code) & (state_reg == ev_state))
      ev_hit = 1'b0;
  end

  // Checks on a requested transition
  always @* begin
    rq_err  = 1'b1;
    rq_code = `FALSR_EC_NONE;
    case (state_req)
      `FALSR_ST_INIT: begin
        rq_err = 1'b0;
      end
      `FALSR_ST_PREOP: begin
        rq_err = 1'b0;
      end
      `FALSR_ST_BOOT: begin
        rq_code = st_init ? `FALSR_EC_NOBOOT : `FALSR_EC_BADCHANGE;
      end
      `FALSR_ST_SAFEOP: begin
        if (st_init)
          rq_code = `FALSR_EC_BADCHANGE;
        else if (st_pre & sm_cfg_bad)
          rq_code = `FALSR_EC_SMCFG;
        else if (st_pre & freerun_no_3buf)
          rq_code = `FALSR_EC_FREERUN3B;
        else if (st_pre & dc_sync_cfg_bad)
          rq_code = `FALSR_EC_DCSYNCCFG;
        else if (st_pre & dc_latch_cfg_bad)
          rq_code = `FALSR_EC_DCLATCHCFG;
        else if (st_pre & dc_cycle_bad)
          rq_code = `FALSR_EC_DCCYCLE;
        else
          rq_err = 1'b0;
      end
      `FALSR_ST_OP: begin
        if (st_init | st_pre)
          rq_code = `FALSR_EC_BADCHANGE;
        else if (st_safe & sm_cfg_bad)
          rq_code = `FALSR_EC_SMCFG;
        else if (st_safe & ~inputs_valid & ~outputs_valid)
          rq_code = `FALSR_EC_NOIO;
        else if (st_safe & ~inputs_valid)
          rq_code = `FALSR_EC_NOINPUTS;
        else if (st_safe & dc_sync_cfg_bad)
          rq_code = `FALSR_EC_DCSYNCCFG;
        else if (st_safe & dc_latch_cfg_bad)
          rq_code = `FALSR_EC_DCLATCHCFG;
        else if (st_safe & dc_sync_timeout)
          rq_code = `FALSR_EC_DCTIMEOUT;
        else
          rq_err = 1'b0;
      end
      default: begin
        rq_code = `FALSR_EC_UNKNOWN;
      end
    endcase
  end

  // Next state, flag and code; a fresh event wins over a request
  always @* begin
    state_next = state_reg;
    err_next   = err_reg;
    code_next  = code_reg;
    if (ev_hit) begin
      state_next = ev_state;
      err_next   = 1'b1;
      code_next  = ev_code;
    end else if (state_req_valid & rq_err) begin
      state_next = st_op ? `FALSR_ST_SAFEOP : state_reg;
      err_next   = 1'b1;
      code_next  = rq_code;
    end else if (state_req_valid) begin
      state_next = state_req;
      err_next   = 1'b0;
      code_next  = `FALSR_EC_NONE;
    end
  end

  // Fieldbus state, error flag and error code
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= `FALSR_ST_INIT;
      err_reg   <= 1'b0;
      code_reg  <= `FALSR_EC_NONE;
    end else begin
      state_reg <= state_next;
      err_reg   <= err_next;
      code_reg  <= code_next;
    end
  end

  // Millisecond watchdog, restarted by each process data frame
  always @(posedge aclk) begin
    if (!aresetn) begin
      pre_reg <= {PRE_W{1'b0}};
      ms_reg  <= 16'h0000;
    end else if (pd_valid | ~st_op) begin
      pre_reg <= {PRE_W{1'b0}};
      ms_reg  <= 16'h0000;
    end else if (pre_reg == PRE_LAST) begin
      pre_reg <= {PRE_W{1'b0}};
      if (ms_reg != 16'hFFFF)
        ms_reg <= ms_reg + 16'h0001;
    end else begin
      pre_reg <= pre_reg + {{(PRE_W-1){1'b0}}, 1'b1};
    end
  end

  // Alias written by master is caught once after reset
  always @(posedge aclk) begin
    if (!aresetn) begin
      alias_boot_reg   <= `FALSR_RST_ALIAS;
      alias_caught_reg <= 1'b0;
    end else if (!alias_caught_reg) begin
      alias_boot_reg   <= master_alias;
      alias_caught_reg <= 1'b1;
    end
  end

  // Control and status word translation by operate mode
  always @(posedge aclk) begin
    if (!aresetn) begin
      pd_ctrl_reg    <= 16'h0000;
      drv_ctrl_word  <= 16'h0000;
      pd_status_word <= 16'h0000;
    end else begin
      if (pd_valid)
        pd_ctrl_reg <= pd_ctrl_word;
      case (mode_reg)
        `FALSR_MODE_PROFILE: begin
          drv_ctrl_word  <= falsr_ctrl_to_drive(pd_ctrl_reg);
          pd_status_word <= falsr_stat_to_profile(drv_status_word);
        end
        `FALSR_MODE_BYPASS: begin
          drv_ctrl_word  <= pd_ctrl_reg;
          pd_status_word <= drv_status_word;
        end
        default: begin
          drv_ctrl_word  <= 16'h0000;
          pd_status_word <= 16'h0000;
        end
      endcase
    end
  end

  // Monitor outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      al_state                   <= `FALSR_ST_INIT;
      al_error_flag              <= 1'b0;
      app_layer_error_code       <= `FALSR_EC_NONE;
      operate_mode               <= `FALSR_RST_MODE;
      sync_manager_watchdog_time <= `FALSR_RST_WDTIME;
      station_alias_used         <= `FALSR_RST_ALIAS;
    end else begin
      al_state                   <= state_next;
      al_error_flag              <= err_next;
      app_layer_error_code       <= code_next;
      operate_mode               <= mode_reg;
      sync_manager_watchdog_time <= wdtime_reg;
      station_alias_used         <= alias_now;
    end
  end

  // AXI write channels and register writes
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `FALSR_RESP_OKAY;
      mode_reg      <= `FALSR_RST_MODE;
      wdtime_reg    <= `FALSR_RST_WDTIME;
      aliaspar_reg  <= `FALSR_RST_ALIAS;
    end else begin
      aw_full_reg   <= aw_full_n;
      w_full_reg    <= w_full_n;
      s_axi_awready <= ~aw_full_n;
      s_axi_wready  <= ~w_full_n;
      if (aw_take)
        awaddr_reg <= s_axi_awaddr;
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (b_done)
        s_axi_bvalid <= 1'b0;
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `FALSR_RESP_OKAY;
        case ({awaddr_reg[7:2], 2'b00})
          `FALSR_OFS_MODE:
            mode_reg <= mode_wr[1:0];
          `FALSR_OFS_WDTIME:
            wdtime_reg <= wdt_wr[15:0];
          `FALSR_OFS_ALIASPAR:
            aliaspar_reg <= alias_wr[15:0];
          `FALSR_OFS_STATE, `FALSR_OFS_ERRCODE, `FALSR_OFS_ALIASUSED,
          `FALSR_OFS_WORDS: begin
            s_axi_bresp <= `FALSR_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `FALSR_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // Read decode
  always @* begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `FALSR_OFS_MODE:      rd_val = {30'h0, mode_reg};
      `FALSR_OFS_WDTIME:    rd_val = {16'h0, wdtime_reg};
      `FALSR_OFS_ALIASPAR:  rd_val = {16'h0, aliaspar_reg};
      `FALSR_OFS_STATE: begin
        rd_val[`FALSR_STATE_MSB:`FALSR_STATE_LSB] = state_reg;
        rd_val[`FALSR_ERRFLAG_BIT]               = err_reg;
        rd_val[`FALSR_MODE_MSB:`FALSR_MODE_LSB]  = mode_reg;
      end
      `FALSR_OFS_ERRCODE:   rd_val = {16'h0, code_reg};
      `FALSR_OFS_ALIASUSED: rd_val = {16'h0, alias_now};
      `FALSR_OFS_WORDS:     rd_val = {pd_status_word, drv_ctrl_word};
      default:              rd_ok  = 1'b0;
    endcase
  end

  // AXI read channels
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `FALSR_RESP_OKAY;
    end else begin
      s_axi_rvalid  <= rvalid_n;
      s_axi_arready <= ~rvalid_n;
      if (ar_take) begin
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? `FALSR_RESP_OKAY : `FALSR_RESP_SLVERR;
      end
    end
  end

endmodule

// file: verilog/falsr_defs.vh
`ifndef FALSR_DEFS_VH
`define FALSR_DEFS_VH

// Register byte offsets
`define FALSR_OFS_MODE       8'h00
`define FALSR_OFS_WDTIME     8'h04
`define FALSR_OFS_ALIASPAR   8'h08
`define FALSR_OFS_STATE      8'h0C
`define FALSR_OFS_ERRCODE    8'h10
`define FALSR_OFS_ALIASUSED  8'h14
`define FALSR_OFS_WORDS      8'h18

// Field positions in the state register
`define FALSR_STATE_LSB      0
`define FALSR_STATE_MSB      3
`define FALSR_ERRFLAG_BIT    4
`define FALSR_MODE_LSB       8
`define FALSR_MODE_MSB       9

// Reset values
`define FALSR_RST_MODE       2'h1
`define FALSR_RST_WDTIME     16'h0000
`define FALSR_RST_ALIAS      16'h0000

// Operate modes
`define FALSR_MODE_NONE      2'h1
`define FALSR_MODE_PROFILE   2'h2
`define FALSR_MODE_BYPASS    2'h3

// State codes (one-hot except boot, which is a request only)
`define FALSR_ST_INIT        4'h1
`define FALSR_ST_PREOP       4'h2
`define FALSR_ST_BOOT        4'h3
`define FALSR_ST_SAFEOP      4'h4
`define FALSR_ST_OP          4'h8

// Error codes
`define FALSR_EC_NONE        16'h0000
`define FALSR_EC_BADCHANGE   16'h0011
`define FALSR_EC_UNKNOWN     16'h0012
`define FALSR_EC_NOBOOT      16'h0013
`define FALSR_EC_SMCFG       16'h0017
`define FALSR_EC_NOINPUTS    16'h0018
`define FALSR_EC_SMWDOG      16'h001B
`define FALSR_EC_COLDSTART   16'h0020
`define FALSR_EC_FREERUN3B   16'h0029
`define FALSR_EC_NOIO        16'h002B
`define FALSR_EC_DCSYNCCFG   16'h0030
`define FALSR_EC_DCLATCHCFG  16'h0031
`define FALSR_EC_DCTIMEOUT   16'h0034
`define FALSR_EC_DCCYCLE     16'h0035
`define FALSR_EC_IDUPDATE    16'h0061

// AXI responses
`define FALSR_RESP_OKAY      2'h0
`define FALSR_RESP_SLVERR    2'h2

// Timing
`define FALSR_CLK_NS         5
`define FALSR_MS_NS          1000000

`endif

// file: bench/falsr_properties.sv
`timescale 1ns/100ps
module falsr_checker (
  // Clock and reset
  input logic        aclk,
  input logic        aresetn,
  // Requests and conditions
  input logic        state_req_valid,
  input logic [3:0]  state_req,
  input logic        cold_start_req,
  input logic        inputs_valid,
  input logic        outputs_valid,
  // Process data words
  input logic        pd_valid,
  input logic [15:0] pd_ctrl_word,
  input logic [15:0] drv_status_word,
  input logic [15:0] drv_ctrl_word,
  input logic [15:0] pd_status_word,
  // Status outputs
  input logic [3:0]  al_state,
  input logic        al_error_flag,
  input logic [15:0] app_layer_error_code,
  input logic [1:0]  operate_mode
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Request seen in Init with no cold start pending
  sequence s_init_req;
    state_req_valid && al_state == 4'h1 && !cold_start_req;
  endsequence
  // Frame taken, pass-through shown when its word reaches the drive
  sequence s_bypass_frame;
    pd_valid ##2 operate_mode == 2'h3;
  endsequence
  // Op with cold start clear
  sequence s_op_ok;
    al_state == 4'h8 && !cold_start_req;
  endsequence
  chk_forbid_init:
    assert property (s_init_req ##0 (state_req == 4'h4 || state_req == 4'h8)
      |=> app_layer_error_code == 16'h0011 && al_error_flag)
    else $error("forbidden request not flagged");
  chk_unknown_req:
    assert property (s_init_req ##0
      !(state_req inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8})
      |=> app_layer_error_code == 16'h0012 && al_error_flag)
    else $error("unknown request not flagged");
  chk_ack_clears:
    assert property (s_init_req ##0 state_req == 4'h1
      |=> !al_error_flag && app_layer_error_code == 16'h0000)
    else $error("acknowledge did not clear");
  chk_flag_holds:
    assert property (al_error_flag && !state_req_valid |=> al_error_flag)
    else $error("error flag dropped");
  chk_code_flag:
    assert property (app_layer_error_code != 16'h0000
      |-> al_error_flag && al_state inside {4'h1, 4'h2, 4'h4})
    else $error("error code without error state");
  chk_cold_op:
    assert property (cold_start_req && al_state == 4'h8 |=> al_state == 4'h4
      && al_error_flag && app_layer_error_code == 16'h0020)
    else $error("cold start in op wrong");
  chk_no_io:
    assert property (s_op_ok ##0 !inputs_valid && !outputs_valid
      |=> al_state == 4'h4 && app_layer_error_code == 16'h002B)
    else $error("no io in op wrong");
  chk_no_inputs:
    assert property (s_op_ok ##0 !inputs_valid && outputs_valid
      |=> al_state == 4'h4 && app_layer_error_code == 16'h0018)
    else $error("no inputs in op wrong");
  chk_bypass_ctrl:
    assert property (s_bypass_frame |-> drv_ctrl_word == $past(pd_ctrl_word, 2))
    else $error("control word altered");
  chk_bypass_stat:
    assert property (operate_mode == 2'h3
      |-> pd_status_word == $past(drv_status_word))
    else $error("status word altered");
  chk_profile_stat:
    assert property (operate_mode == 2'h2 |-> pd_status_word[5]
      && pd_status_word[9] && pd_status_word[2] == $past(drv_status_word[1]))
    else $error("profile status wrong");
endmodule

bind falsr_top falsr_checker i_falsr_checker (.aclk, .aresetn,
  .state_req_valid, .state_req, .cold_start_req, .inputs_valid,
  .outputs_valid, .pd_valid, .pd_ctrl_word, .drv_status_word,
  .drv_ctrl_word, .pd_status_word, .al_state, .al_error_flag,
  .app_layer_error_code, .operate_mode);

// file: bench/falsr_partner.sv
`timescale 1ns/100ps
module falsr_partner (
  // Clock and control
  input  logic        aclk,
  input  logic        pd_run,
  input  logic [15:0] pd_word,
  // Process data toward the block
  output logic        pd_valid = 1'b0,
  output logic [15:0] pd_ctrl_word = 16'h0000
);
  logic [1:0] gap_reg = 2'h0;
  // One frame every four cycles, word churns between frames
  always @(posedge aclk) begin
    gap_reg      <= gap_reg + 2'h1;
    pd_valid     <= pd_run && gap_reg == 2'h3;
    pd_ctrl_word <= (pd_run && gap_reg == 2'h3) ? pd_word : ~pd_ctrl_word;
  end
endmodule

// file: bench/fieldbus_al_status_reporter_tb_top.sv
`timescale 1ns/100ps
module fieldbus_al_status_reporter_tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0]  state_req = 4'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, state_req_valid = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, pd_valid;
  logic        pd_run = 1'b0;
  logic [9:0]  ev_vec = 10'h000;
  logic [15:0] master_alias = 16'h0000, drv_status_word = 16'h0000;
  logic [15:0] pd_word = 16'h0000, pd_ctrl_word;
  logic [15:0] wd_time_o, alias_used_o;
  logic [33:0] rq[$], bq[$];
  int          fails = 0, total_checks = 0, i;
  // Request, resulting state, flag and code from Init onward
  logic [27:0] stab [13] = '{28'h411_0011, 28'h110_0000, 28'h811_0011,
    28'h311_0013, 28'h511_0012, 28'h220_0000, 28'h821_0011, 28'h321_0011,
    28'h440_0000, 28'h341_0011, 28'h880_0000, 28'h341_0011, 28'h110_0000};

  falsr_top #(.MS_CYCLES(10)) i_falsr_top (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .state_req_valid, .state_req,
    .cold_start_req(ev_vec[0]), .sm_cfg_bad(ev_vec[1]),
    .freerun_no_3buf(ev_vec[2]), .dc_sync_cfg_bad(ev_vec[3]),
    .dc_latch_cfg_bad(ev_vec[4]), .dc_sync_timeout(ev_vec[5]),
    .dc_cycle_bad(ev_vec[6]), .dev_id_update(ev_vec[7]),
    .inputs_valid(!ev_vec[8]), .outputs_valid(!ev_vec[9]), .master_alias,
    .pd_valid, .pd_ctrl_word, .drv_status_word, .drv_ctrl_word(),
    .pd_status_word(), .al_state(), .al_error_flag(),
    .app_layer_error_code(), .operate_mode(),
    .sync_manager_watchdog_time(wd_time_o),
    .station_alias_used(alias_used_o));
  falsr_partner i_falsr_partner (.aclk, .pd_run, .pd_word, .pd_valid,
    .pd_ctrl_word);

  // Clock
  always #2.5 aclk = ~aclk;

  // Compare one result with its note
  task automatic cmp(input [33:0] got, input [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Monitor pops the oldest note at each response
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
      cmp({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
      cmp({32'h0000_0000, s_axi_bresp}, bq.pop_front());
  end

  task automatic wr(input [7:0] a, input [31:0] d, input [1:0] r);
    bit aw = 0, w = 0;
    @(posedge aclk);
    bq.push_back({32'h0000_0000, r});
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      aw |= s_axi_awready;
      w  |= s_axi_wready;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input [7:0] a, input [31:0] d, input [1:0] r);
    @(posedge aclk);
    rq.push_back({r, d});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // One-cycle state request together with condition mask
  task automatic req(input [3:0] s, input [9:0] m);
    @(posedge aclk);
    state_req       <= s;
    state_req_valid <= s != 4'h0;
    ev_vec          <= m;
    @(posedge aclk);
    state_req_valid <= 1'b0;
    ev_vec          <= 10'h000;
  endtask

  task automatic look(input [3:0] st, input f, input [15:0] c);
    rd(8'h0C, {22'h00_0000, 2'h1, 3'h0, f, st}, 2'h0);
    rd(8'h10, {16'h0000, c}, 2'h0);
  endtask

  // Acknowledge to Init, then climb n states
  task automatic go(input int n);
    req(4'h1, 10'h000);
    for (int k = 0; k < n; k++) req(4'h2 << k, 10'h000);
  endtask

  task automatic ev_case(input int n, input [9:0] m, input [3:0] r,
                         input [3:0] st, input [15:0] c);
    go(n);
    req(r, m);
    look(st, 1'b1, c);
  endtask

  function automatic [31:0] words(input [1:0] m, input [15:0] c, s);
    if (m == 2'h3) return {s, c};
    if (m == 2'h2) return {6'h00, 1'b1, 1'b0, s[2], 1'b0, 1'b1, s[0], s[3],
      s[1], s[0], s[0], 13'h0000, c[7], 1'b0, &c[3:0]};
    return 32'h0000_0000;
  endfunction

  task tally_and_finish;
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    tally_and_finish;
  end

  // Main sequence
  initial begin
    void'($urandom(32'h697c_fc0e));
    @(posedge aclk);
    master_alias <= 16'($urandom);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 32'h1, 2'h0);
    rd(8'h04, 32'h0, 2'h0);
    cmp(wd_time_o, 16'h0000);
    look(4'h1, 1'b0, 16'h0000);
    rd(8'h14, {16'h0000, master_alias}, 2'h0);
    cmp(alias_used_o, master_alias);
    rd(8'h1C, 32'h0, 2'h2);
    wr(8'h1C, 32'h5, 2'h2);
    wr(8'h10, 32'h77, 2'h0);
    rd(8'h10, 32'h0, 2'h0);
    wr(8'h08, 32'h1234, 2'h0);
    rd(8'h14, 32'h1234, 2'h0);
    cmp(alias_used_o, 16'h1234);
    wr(8'h08, 32'h0, 2'h0);
    $display("test registers done");
    foreach (stab[k]) begin
      req(stab[k][27:24], 10'h000);
      look(stab[k][23:20], stab[k][16], stab[k][15:0]);
    end
    $display("test requests done");
    ev_case(3, 10'h001, 4'h0, 4'h4, 16'h0020);
    ev_case(1, 10'h001, 4'h0, 4'h2, 16'h0020);
    ev_case(2, 10'h002, 4'h8, 4'h4, 16'h0017);
    ev_case(1, 10'h004, 4'h4, 4'h2, 16'h0029);
    ev_case(3, 10'h008, 4'h0, 4'h4, 16'h0030);
    ev_case(1, 10'h010, 4'h4, 4'h2, 16'h0031);
    ev_case(3, 10'h020, 4'h0, 4'h4, 16'h0034);
    ev_case(1, 10'h040, 4'h4, 4'h2, 16'h0035);
    ev_case(1, 10'h080, 4'h0, 4'h2, 16'h0061);
    ev_case(3, 10'h100, 4'h0, 4'h4, 16'h0018);
    ev_case(3, 10'h300, 4'h0, 4'h4, 16'h002B);
    $display("test errors done");
    wr(8'h04, 32'h2, 2'h0);
    rd(8'h04, 32'h2, 2'h0);
    cmp(wd_time_o, 16'h0002);
    pd_run <= 1'b1;
    go(3);
    repeat (40) @(posedge aclk);
    look(4'h8, 1'b0, 16'h0000);
    pd_run <= 1'b0;
    repeat (40) @(posedge aclk);
    look(4'h4, 1'b1, 16'h001B);
    wr(8'h04, 32'h0, 2'h0);
    go(0);
    $display("test watchdog done");
    pd_run <= 1'b1;
    for (i = 0; i < 4; i++) begin
      wr(8'h00, i, 2'h0);
      rd(8'h00, i, 2'h0);
      pd_word         <= 16'($urandom);
      drv_status_word <= 16'($urandom);
      repeat (12) @(posedge aclk);
      rd(8'h18, words(i[1:0], pd_word, drv_status_word), 2'h0);
    end
    $display("test words done");
    tally_and_finish;
  end
endmodule
